// File: design/chs_homing.sv
// Count-type and stopper-type homing sequencer with Wishbone registers
// Notes on behaviour
// RULE1: after switch edge, cover post-switch travel first
// RULE2: then first index pulse becomes home
// RULE3: switch length irrelevant; only leading edge used
// RULE4: method -34 mirrors -2 direction
// RULE5: method -36 mirrors -4 direction
// RULE6: method -4 uses positive torque limit
// RULE7: method -36 uses negative torque limit
// RULE8: reached torque limit flag survives completion
// RULE9: I/O mode loads home value on completion
// RULE10: home value from two writable parameters
// RULE11: dwell at stopper before declaring home
// RULE12: stopper torque during search, normal otherwise
// RULE13: no reversal at limits; stroke end aborts
// RULE14: configurer keeps stopper search speed low
// RULE15: controller prefers count type for short switches
// RULE16: start bit 4; status bits 10, 12
// RULE17: motion starts well within 10 ms of start
`timescale 1ns/1ps
`include "chs_cfg.svh"

module chs_homing
	import chs_pkg::*;
#(
	parameter int MS_CYCLES = `CHS_MS_CYCLES  // Cycles per millisecond
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// Wishbone slave
	input  wire logic        WB_CYC,
	input  wire logic        WB_STB,
	input  wire logic        WB_WE,
	input  wire logic [5:0]  WB_ADR,
	input  wire logic [3:0]  WB_SEL,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK,
	// Sensors
	input  wire logic        PROX_SW,
	input  wire logic        ENC_INDEX,
	input  wire logic        POS_STEP,
	input  wire logic        TORQUE_AT_LIMIT,
	input  wire logic        STROKE_END,
	// Motion command
	output logic             MOTION_RUN,
	output logic             MOTION_REV,
	output logic             MOTION_CREEP,
	output logic [15:0]      TORQUE_CEILING,
	output logic             TORQUE_LIMIT_REACHED,
	// Position load
	output logic             HOME_POS_LOAD,
	output logic [31:0]      HOME_POS,
	// Interrupt
	output logic             IRQ
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic             ack_r, ack_nxt;            // Bus answer
	logic [31:0]      rdat_r, rdat_nxt;          // Read data
	logic             io_mode_r, io_mode_nxt;    // I/O mode select
	logic             start_r, start_nxt;        // Control word bit 4
	logic [7:0]       method_r, method_nxt;      // Selected homing method
	logic [31:0]      travel_r, travel_nxt;      // Post-switch travel
	logic [15:0]      dwell_r, dwell_nxt;        // Stopper dwell in ms
	logic [15:0]      stop_tq_r, stop_tq_nxt;    // Stopper search torque
	logic [15:0]      pos_tq_r, pos_tq_nxt;      // Positive torque limit
	logic [15:0]      neg_tq_r, neg_tq_nxt;      // Negative torque limit
	logic [15:0]      home_lo_r, home_lo_nxt;    // Home value, low half
	logic [15:0]      home_hi_r, home_hi_nxt;    // Home value, high half
	logic [2:0]       irq_st_r, irq_st_nxt;      // Sticky event bits
	logic [2:0]       irq_mk_r, irq_mk_nxt;      // Event mask
	chs_state_t       st_r, st_nxt;              // Sequencer state
	logic [31:0]      dist_r, dist_nxt;          // Remaining travel
	logic [15:0]      ms_r, ms_nxt;              // Dwell milliseconds
	logic             prox_d_r, prox_d_nxt;      // Switch, last cycle
	logic             start_d_r, start_d_nxt;    // Start bit, last cycle
	logic             tlc_r, tlc_nxt;            // Torque-limit-reached output
	logic             tlc_hold_r, tlc_hold_nxt;  // Stopper hit latched
	logic             load_r, load_nxt;          // Position load strobe
	logic [31:0]      hpos_r, hpos_nxt;          // Position load value
	logic [15:0]      tq_r, tq_nxt;              // Torque ceiling output
	logic             wr_en;                     // Write takes effect
	logic             ms_tick;                   // Millisecond pulse
	logic             start_edge;                // Start bit rose
	logic             ev_done, ev_fault, ev_tlc; // Events this cycle
	logic [2:0]       ev_vec;                    // Events as a vector
	logic             moving;                    // Sequencer in seek, shift, index or dwell

	// ----------------------------------------------------------------
	// Millisecond timebase
	// ----------------------------------------------------------------
	chs_ms_tick #(
		.MS_CYCLES (MS_CYCLES)
	) u_tick (
		.clk  (CLK_SYS),
		.rst  (RST),
		.clr  (st_r != CHS_DWELL),
		.tick (ms_tick)
	);

	// Writes land on the edge where the master sees ack
	assign wr_en      = WB_CYC && WB_STB && WB_WE && ack_r;
	assign start_edge = start_r && !start_d_r;
	assign moving     = (st_r == CHS_SEEK) || (st_r == CHS_SHIFT) || (st_r == CHS_INDEX)
			|| (st_r == CHS_DWELL);
	assign ev_vec     = {ev_tlc, ev_fault, ev_done};

	// ----------------------------------------------------------------
	// Register file, next values
	// ----------------------------------------------------------------
	// Byte lane 0 is honoured only for the control, method and IRQ registers;
	// the 16- and 32-bit fields are written whole, which software always does anyway
	always_comb begin
		ack_nxt     = WB_CYC && WB_STB && !ack_r;
		rdat_nxt    = 32'h0000_0000;
		io_mode_nxt = io_mode_r;
		start_nxt   = start_r;
		method_nxt  = method_r;
		travel_nxt  = travel_r;
		dwell_nxt   = dwell_r;
		stop_tq_nxt = stop_tq_r;
		pos_tq_nxt  = pos_tq_r;
		neg_tq_nxt  = neg_tq_r;
		home_lo_nxt = home_lo_r;
		home_hi_nxt = home_hi_r;
		irq_mk_nxt  = irq_mk_r;
		irq_st_nxt  = irq_st_r;
		// Read mux, captured while the answer is prepared
		case (WB_ADR)
			`CHS_ADR_CTRL: begin
				rdat_nxt[`CHS_CTRL_IO_MODE] = io_mode_r;
				rdat_nxt[`CHS_CTRL_START]   = start_r;
			end
			`CHS_ADR_STATUS: begin
				rdat_nxt[`CHS_STAT_TLC]      = tlc_r;
				rdat_nxt[`CHS_STAT_FAULT]    = (st_r == CHS_FAULT);
				rdat_nxt[`CHS_STAT_TARGET]   = !moving;               // see RULE16
				rdat_nxt[`CHS_STAT_ATTAINED] = (st_r == CHS_DONE);    // see RULE16
			end
			`CHS_ADR_METHOD:   rdat_nxt[7:0]  = method_r;
			`CHS_ADR_TRAVEL:   rdat_nxt       = travel_r;
			`CHS_ADR_DWELL:    rdat_nxt[15:0] = dwell_r;
			`CHS_ADR_STOP_TQ:  rdat_nxt[15:0] = stop_tq_r;
			`CHS_ADR_POS_TQ:   rdat_nxt[15:0] = pos_tq_r;
			`CHS_ADR_NEG_TQ:   rdat_nxt[15:0] = neg_tq_r;
			`CHS_ADR_HOME_LO:  rdat_nxt[15:0] = home_lo_r;
			`CHS_ADR_HOME_HI:  rdat_nxt[15:0] = home_hi_r;
			`CHS_ADR_IRQ_STAT: rdat_nxt[2:0]  = irq_st_r;
			`CHS_ADR_IRQ_MASK: rdat_nxt[2:0]  = irq_mk_r;
			default:           rdat_nxt       = 32'h0000_0000;  // Unmapped reads zero
		endcase
		// Write decode
		if (wr_en) begin
			case (WB_ADR)
				`CHS_ADR_CTRL: begin
					if (WB_SEL[0]) begin
						io_mode_nxt = WB_DAT_I[`CHS_CTRL_IO_MODE];
						start_nxt   = WB_DAT_I[`CHS_CTRL_START];    // see RULE16
					end
				end
				`CHS_ADR_METHOD:   if (WB_SEL[0]) method_nxt = WB_DAT_I[7:0];
				`CHS_ADR_TRAVEL:   travel_nxt = WB_DAT_I;
				`CHS_ADR_DWELL:    dwell_nxt  = WB_DAT_I[15:0];
				`CHS_ADR_STOP_TQ:  stop_tq_nxt = WB_DAT_I[15:0];
				`CHS_ADR_POS_TQ:   pos_tq_nxt  = WB_DAT_I[15:0];
				`CHS_ADR_NEG_TQ:   neg_tq_nxt  = WB_DAT_I[15:0];
				`CHS_ADR_HOME_LO:  home_lo_nxt = WB_DAT_I[15:0];    // see RULE10
				`CHS_ADR_HOME_HI:  home_hi_nxt = WB_DAT_I[15:0];    // see RULE10
				`CHS_ADR_IRQ_STAT: if (WB_SEL[0]) irq_st_nxt = irq_st_r & ~WB_DAT_I[2:0];
				`CHS_ADR_IRQ_MASK: if (WB_SEL[0]) irq_mk_nxt = WB_DAT_I[2:0];
				default: begin
					// Writes to unmapped offsets are acknowledged and dropped
				end
			endcase
		end
		// A fresh event beats a clear in the same cycle
		irq_st_nxt = irq_st_nxt | ev_vec;
	end

	// Register file, storage
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ack_r     <= 1'b0;
			rdat_r    <= 32'h0000_0000;
			io_mode_r <= 1'b0;
			start_r   <= 1'b0;
			method_r  <= `CHS_RST_METHOD;
			travel_r  <= `CHS_RST_TRAVEL;
			dwell_r   <= `CHS_RST_DWELL;
			stop_tq_r <= `CHS_RST_TQ;
			pos_tq_r  <= `CHS_RST_TQ;
			neg_tq_r  <= `CHS_RST_TQ;
			home_lo_r <= `CHS_RST_HOME;
			home_hi_r <= `CHS_RST_HOME;
			irq_st_r  <= 3'h0;
			irq_mk_r  <= 3'h0;
		end else begin
			ack_r     <= ack_nxt;
			rdat_r    <= rdat_nxt;
			io_mode_r <= io_mode_nxt;
			start_r   <= start_nxt;
			method_r  <= method_nxt;
			travel_r  <= travel_nxt;
			dwell_r   <= dwell_nxt;
			stop_tq_r <= stop_tq_nxt;
			pos_tq_r  <= pos_tq_nxt;
			neg_tq_r  <= neg_tq_nxt;
			home_lo_r <= home_lo_nxt;
			home_hi_r <= home_hi_nxt;
			irq_st_r  <= irq_st_nxt;
			irq_mk_r  <= irq_mk_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer, next values
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt       = st_r;
		dist_nxt     = dist_r;
		ms_nxt       = ms_r;
		prox_d_nxt   = PROX_SW;
		start_d_nxt  = start_r;
		tlc_hold_nxt = tlc_hold_r;
		load_nxt     = 1'b0;
		hpos_nxt     = hpos_r;
		ev_done      = 1'b0;
		ev_fault     = 1'b0;
		ev_tlc       = 1'b0;
		case (st_r)
			CHS_IDLE, CHS_DONE, CHS_FAULT: begin
				// Start with a known method goes straight to motion, far inside 10 ms; an unknown one faults
				if (start_edge) begin                               // see RULE16
					tlc_hold_nxt = 1'b0;
					ms_nxt       = 16'h0000;
					if (chs_is_count(method_r) || chs_is_stop(method_r)) begin
						st_nxt = CHS_SEEK;                          // see RULE17
					end else begin
						st_nxt   = CHS_FAULT;
						ev_fault = 1'b1;
					end
				end
			end
			CHS_SEEK: begin
				if (chs_is_stop(method_r)) begin
					if (TORQUE_AT_LIMIT) begin                      // see RULE11
						st_nxt       = CHS_DWELL;
						tlc_hold_nxt = 1'b1;                        // see RULE8
						ev_tlc       = 1'b1;
					end
				end else if (PROX_SW && !prox_d_r) begin
					// Only the leading edge counts; the far end is never looked at
					st_nxt   = (travel_r == 32'h0000_0000) ? CHS_INDEX : CHS_SHIFT; // see RULE3
					dist_nxt = travel_r;                            // see RULE1
				end
			end
			CHS_SHIFT: begin
				if (POS_STEP) begin
					dist_nxt = dist_r - 32'h0000_0001;
					if (dist_r == 32'h0000_0001) begin
						st_nxt = CHS_INDEX;                         // see RULE1
					end
				end
			end
			CHS_INDEX: begin
				if (ENC_INDEX) begin                                // see RULE2
					st_nxt  = CHS_DONE;
					ev_done = 1'b1;
				end
			end
			CHS_DWELL: begin
				if (ms_tick) begin
					ms_nxt = ms_r + 16'h0001;
				end
				if (ms_r >= dwell_r) begin                          // see RULE11
					st_nxt  = CHS_DONE;
					ev_done = 1'b1;
				end
			end
			default: begin
				st_nxt = CHS_IDLE;
			end
		endcase
		// Stroke end stops the search; no turning back is attempted
		if (moving && STROKE_END) begin                             // see RULE13
			st_nxt   = CHS_FAULT;
			ev_fault = 1'b1;
			ev_done  = 1'b0;
		end
		// Completion loads the home value in I/O mode only
		if (ev_done && !(moving && STROKE_END) && io_mode_r) begin  // see RULE9
			load_nxt = 1'b1;
			hpos_nxt = {home_hi_r, home_lo_r};                      // see RULE10
		end
	end

	// Motion outputs derived from the next state
	always_comb begin
		// Stopper torque only during seek and dwell of a stopper method; direction limits otherwise
		if (chs_is_stop(method_r) && ((st_nxt == CHS_SEEK) || (st_nxt == CHS_DWELL))) begin
			tq_nxt = stop_tq_r;                                     // see RULE12
		end else if (chs_is_rev(method_r)) begin
			tq_nxt = neg_tq_r;                                      // see RULE7
		end else begin
			tq_nxt = pos_tq_r;                                      // see RULE6
		end
		tlc_nxt = tlc_hold_nxt || TORQUE_AT_LIMIT;                  // see RULE8
	end

	// Sequencer storage
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_r       <= CHS_IDLE;
			dist_r     <= 32'h0000_0000;
			ms_r       <= 16'h0000;
			prox_d_r   <= 1'b0;
			start_d_r  <= 1'b0;
			tlc_hold_r <= 1'b0;
			tlc_r      <= 1'b0;
			load_r     <= 1'b0;
			hpos_r     <= 32'h0000_0000;
			tq_r       <= `CHS_RST_TQ;
		end else begin
			st_r       <= st_nxt;
			dist_r     <= dist_nxt;
			ms_r       <= ms_nxt;
			prox_d_r   <= prox_d_nxt;
			start_d_r  <= start_d_nxt;
			tlc_hold_r <= tlc_hold_nxt;
			tlc_r      <= tlc_nxt;
			load_r     <= load_nxt;
			hpos_r     <= hpos_nxt;
			tq_r       <= tq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign WB_ACK               = ack_r;
	assign WB_DAT_O             = rdat_r;
	// Motion holds still while the dwell runs against the stopper
	assign MOTION_RUN           = (st_r == CHS_SEEK) || (st_r == CHS_SHIFT)
			|| (st_r == CHS_INDEX);
	assign MOTION_REV           = chs_is_rev(method_r);         // see RULE4 see RULE5
	assign MOTION_CREEP         = (st_r == CHS_SHIFT) || (st_r == CHS_INDEX);
	assign TORQUE_CEILING       = tq_r;
	assign TORQUE_LIMIT_REACHED = tlc_r;
	assign HOME_POS_LOAD        = load_r;
	assign HOME_POS             = hpos_r;
	assign IRQ                  = |(irq_st_r & irq_mk_r);

endmodule // chs_homing

// File: design/chs_cfg.svh
// Register offsets, field positions, reset values and timing counts of the homing sequencer
`ifndef CHS_CFG_SVH
`define CHS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CHS_ADR_CTRL      6'h00
`define CHS_ADR_STATUS    6'h04
`define CHS_ADR_METHOD    6'h08
`define CHS_ADR_TRAVEL    6'h0C
`define CHS_ADR_DWELL     6'h10
`define CHS_ADR_STOP_TQ   6'h14
`define CHS_ADR_POS_TQ    6'h18
`define CHS_ADR_NEG_TQ    6'h1C
`define CHS_ADR_HOME_LO   6'h20
`define CHS_ADR_HOME_HI   6'h24
`define CHS_ADR_IRQ_STAT  6'h28
`define CHS_ADR_IRQ_MASK  6'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CHS_CTRL_IO_MODE  0
`define CHS_CTRL_START    4
`define CHS_STAT_TLC      0
`define CHS_STAT_FAULT    1
`define CHS_STAT_TARGET   10
`define CHS_STAT_ATTAINED 12
`define CHS_IRQ_DONE      0
`define CHS_IRQ_FAULT     1
`define CHS_IRQ_TLC       2
`define CHS_IRQ_W         3

// ----------------------------------------------------------------
// Method codes (two's complement, 8 bits)
// ----------------------------------------------------------------
`define CHS_M_COUNT_FWD   8'hFE
`define CHS_M_COUNT_REV   8'hDE
`define CHS_M_STOP_FWD    8'hFC
`define CHS_M_STOP_REV    8'hDC

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CHS_RST_METHOD    8'hFE
`define CHS_RST_TRAVEL    32'h0000_0000
`define CHS_RST_DWELL     16'h0064
`define CHS_RST_TQ        16'h03E8
`define CHS_RST_HOME      16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CHS_CLK_PERIOD_PS 5000
`define CHS_MS_PS         1000000000
`define CHS_MS_CYCLES     (`CHS_MS_PS / `CHS_CLK_PERIOD_PS)

`endif

// File: design/chs_pkg.sv
// Types and method decode helpers of the homing sequencer
`include "chs_cfg.svh"

package chs_pkg;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CHS_IDLE  = 3'b000,  // Waiting for a start edge
		CHS_SEEK  = 3'b001,  // Running at homing speed
		CHS_SHIFT = 3'b010,  // Covering travel after the switch
		CHS_INDEX = 3'b011,  // Waiting for the first index pulse
		CHS_DWELL = 3'b100,  // Pressed against the stopper
		CHS_DONE  = 3'b101,  // Home attained
		CHS_FAULT = 3'b110   // Aborted
	} chs_state_t;

	// Count-type method of either direction
	function automatic logic chs_is_count(input logic [7:0] m);
		chs_is_count = (m == `CHS_M_COUNT_FWD) || (m == `CHS_M_COUNT_REV);
	endfunction

	// Stopper-type method of either direction
	function automatic logic chs_is_stop(input logic [7:0] m);
		chs_is_stop = (m == `CHS_M_STOP_FWD) || (m == `CHS_M_STOP_REV);
	endfunction

	// Mirrored method: motion runs in reverse
	function automatic logic chs_is_rev(input logic [7:0] m);
		chs_is_rev = (m == `CHS_M_COUNT_REV) || (m == `CHS_M_STOP_REV);
	endfunction

endpackage : chs_pkg

// File: design/chs_ms_tick.sv
// Millisecond tick generator for the homing sequencer
`timescale 1ns/1ps
`include "chs_cfg.svh"

module chs_ms_tick #(
	parameter int MS_CYCLES = `CHS_MS_CYCLES  // Clock cycles per millisecond
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic clr,    // Restart the millisecond phase
	output logic      tick    // One-cycle pulse each millisecond
);

	logic [31:0] cnt_r;    // Cycle count within the millisecond
	logic [31:0] cnt_nxt;  // Next count
	logic        tick_r;   // Registered tick
	logic        tick_nxt; // Next tick

	// ----------------------------------------------------------------
	// Next count
	// ----------------------------------------------------------------
	// Clearing keeps the first dwell millisecond a full one
	always_comb begin
		cnt_nxt  = cnt_r + 32'h0000_0001;
		tick_nxt = 1'b0;
		if (clr) begin
			cnt_nxt = 32'h0000_0000;
		end else if (cnt_r >= 32'(MS_CYCLES - 1)) begin
			cnt_nxt  = 32'h0000_0000;
			tick_nxt = 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r  <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule // chs_ms_tick

// File: bench/chs_homing_monitor.sv
// Port-level checker for the homing sequencer, bound to its top module
`timescale 1ns/1ps
`include "chs_cfg.svh"

module chs_homing_monitor (
	// Clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST,
	// Wishbone slave
	input wire logic        WB_CYC,
	input wire logic        WB_STB,
	input wire logic        WB_WE,
	input wire logic [5:0]  WB_ADR,
	input wire logic [3:0]  WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK,
	// Sensors and motion
	input wire logic        STROKE_END,
	input wire logic        TORQUE_AT_LIMIT,
	input wire logic        MOTION_RUN,
	input wire logic        MOTION_REV,
	input wire logic        TORQUE_LIMIT_REACHED,
	input wire logic        HOME_POS_LOAD,
	input wire logic [31:0] HOME_POS
);
	// ----
	// Shadow of the start bit and of method validity
	// ----
	logic ctrl_b4_r, ctrl_b4_nxt;  // Last written start bit
	logic meth_ok_r, meth_ok_nxt;  // Method register holds a known code
	logic wr_ack;                  // Write lands at this edge
	assign wr_ack = WB_ACK && WB_WE && WB_SEL[0];
	// Track writes so that only a true 0-to-1 start counts
	always_comb begin
		ctrl_b4_nxt = ctrl_b4_r;
		meth_ok_nxt = meth_ok_r;
		if (wr_ack && WB_ADR == `CHS_ADR_CTRL) begin
			ctrl_b4_nxt = WB_DAT_I[`CHS_CTRL_START];
		end
		if (wr_ack && WB_ADR == `CHS_ADR_METHOD) begin
			meth_ok_nxt = WB_DAT_I[7:0] inside {`CHS_M_COUNT_FWD, `CHS_M_COUNT_REV,
				`CHS_M_STOP_FWD, `CHS_M_STOP_REV};
		end
	end
	// Register the shadow state
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ctrl_b4_r <= 1'b0;
			meth_ok_r <= 1'b1;
		end else begin
			ctrl_b4_r <= ctrl_b4_nxt;
			meth_ok_r <= meth_ok_nxt;
		end
	end
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	chk_ack_single: assert property (WB_ACK |=> !WB_ACK)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property ((WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK)
		else $error("bus request not answered in one cycle");
	chk_unmapped_zero: assert property ((WB_ACK && !WB_WE && WB_ADR > 6'h2C) |->
		WB_DAT_O == 32'h0) else $error("unmapped read not zero");
	chk_load_single: assert property (HOME_POS_LOAD |=> !HOME_POS_LOAD)
		else $error("home load pulse too long");
	chk_load_halted: assert property (HOME_POS_LOAD |-> !MOTION_RUN)
		else $error("home loaded while moving");
	chk_home_held: assert property ($changed(HOME_POS) |-> HOME_POS_LOAD)
		else $error("home value changed without load");
	chk_stroke_abort: assert property ((STROKE_END && MOTION_RUN) |-> ##[1:3] !MOTION_RUN)
		else $error("stroke end did not stop motion");
	chk_tlc_follow: assert property (TORQUE_AT_LIMIT |=> TORQUE_LIMIT_REACHED)
		else $error("torque limit flag missing");
	chk_dir_steady: assert property ((MOTION_RUN && $past(MOTION_RUN)) |->
		$stable(MOTION_REV)) else $error("direction changed while moving");
	chk_start_run: assert property ((wr_ack && WB_ADR == `CHS_ADR_CTRL &&
		WB_DAT_I[`CHS_CTRL_START] && !ctrl_b4_r && meth_ok_r && !MOTION_RUN &&
		!TORQUE_LIMIT_REACHED && !STROKE_END) |-> ##2 MOTION_RUN)
		else $error("start did not launch motion");
endmodule : chs_homing_monitor

bind chs_homing chs_homing_monitor chs_homing_monitor_inst (
	.CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
	.WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK(WB_ACK), .STROKE_END(STROKE_END), .TORQUE_AT_LIMIT(TORQUE_AT_LIMIT),
	.MOTION_RUN(MOTION_RUN), .MOTION_REV(MOTION_REV),
	.TORQUE_LIMIT_REACHED(TORQUE_LIMIT_REACHED), .HOME_POS_LOAD(HOME_POS_LOAD),
	.HOME_POS(HOME_POS));

// File: bench/chs_plant.sv
// Behavioural axis, switch, encoder and stopper model facing the sequencer
`timescale 1ns/1ps

module chs_plant (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Command side
	input  wire logic        clr,
	input  wire logic        run,
	input  wire logic        rev,
	input  wire logic [15:0] ceil,
	input  wire logic [7:0]  stop_at,
	// Sensor side
	output logic             prox,
	output logic             index,
	output logic             step,
	output logic             tq,
	output int               pos
);
	int ph_r;  // Step phase, one step every four cycles
	int ap;    // Distance from the start point
	assign ap = (pos < 0) ? -pos : pos;
	// ----
	// Axis motion
	// ----
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_r <= 0;
			pos <= 0;
			step <= 1'b0;
			index <= 1'b0;
		end else begin
			ph_r <= (ph_r + 1) % 4;
			step <= run && (ph_r == 3);
			// Z pulse mid-step, only while moving, so it never races a step
			index <= run && (ph_r == 1) && (ap % 16 == 0);
			if (clr) begin
				pos <= 0;
			end else if (run && ph_r == 3) begin
				pos <= rev ? pos - 1 : pos + 1;
			end
		end
	end
	// Switch spans 60 steps, well over the minimum on-time in cycles
	assign prox = (ap >= 30) && (ap < 90);
	// Slow search stops dead at the stopper; pushes back only on the weak ceiling
	assign tq = (ap >= stop_at) && (ceil < 16'h0100);
endmodule : chs_plant

// File: bench/chs_homing_tb.sv
// Self-checking testbench of the homing sequencer
`timescale 1ns/1ps
`include "chs_cfg.svh"

module chs_homing_tb;
	localparam int MSC = 20;  // Short millisecond keeps dwell runs brief
	logic CLK_SYS = 0, RST = 1, cyc = 0, stb = 0, we = 0, stroke = 0, clr = 0;
	logic [5:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] dati = 0, dato, hpos, lasthp = 0;
	logic [15:0] ceil;
	logic [7:0]  stop_at = 8'hFF;
	logic        ack, run, rev, creep, torque_limit_reached, load, irq, prox, idx, stp, tq;
	logic [7:0]  mt [4] = '{`CHS_M_COUNT_FWD, `CHS_M_COUNT_REV, `CHS_M_STOP_FWD, `CHS_M_STOP_REV};
	int          pos, errors = 0, checks = 0, loads = 0;

	always #2.5 CLK_SYS = ~CLK_SYS;
	always @(negedge CLK_SYS) if (load === 1'b1) loads++;

	chs_homing #(.MS_CYCLES(MSC)) chs_homing_inst (.CLK_SYS(CLK_SYS), .RST(RST),
		.WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel),
		.WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK(ack), .PROX_SW(prox),
		.ENC_INDEX(idx), .POS_STEP(stp), .TORQUE_AT_LIMIT(tq), .STROKE_END(stroke),
		.MOTION_RUN(run), .MOTION_REV(rev), .MOTION_CREEP(creep),
		.TORQUE_CEILING(ceil), .TORQUE_LIMIT_REACHED(torque_limit_reached), .HOME_POS_LOAD(load),
		.HOME_POS(hpos), .IRQ(irq));
	chs_plant chs_plant_inst (.clk(CLK_SYS), .rst(RST), .clr(clr), .run(run),
		.rev(rev), .ceil(ceil), .stop_at(stop_at), .prox(prox), .index(idx),
		.step(stp), .tq(tq), .pos(pos));

	// ----
	// Shared tasks
	// ----
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled high
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLK_SYS);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dati <= d;
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dato;
		if (n >= 20) errors++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Fresh start: drop the start bit, zero the axis, raise the start bit
	task go(input logic io);
		wr(`CHS_ADR_CTRL, {31'h0, io});
		clr <= 1'b1;
		@(posedge CLK_SYS);
		clr <= 1'b0;
		wr(`CHS_ADR_CTRL, 32'h10 | io);
	endtask

	// ----
	// One homing run with random settings, checked against a model
	// ----
	task home(input logic [7:0] m, input logic stop, input logic rv);
		int t, dw, ptq, ntq, stq, dtq, rc, lc, n, e;
		logic [15:0] hi, lo;
		logic io;
		t = $urandom_range(40, 0);
		dw = $urandom_range(3, 1);
		ptq = $urandom_range(16'hFFFF, 16'h0100);
		ntq = $urandom_range(16'hFFFF, 16'h0100);
		stq = $urandom_range(16'h00FF, 16'h0010);
		hi = $urandom;
		lo = $urandom;
		io = $urandom_range(1, 0);
		dtq = rv ? ntq : ptq;
		wr(`CHS_ADR_METHOD, {24'h0, m});
		wr(`CHS_ADR_TRAVEL, t);
		wr(`CHS_ADR_DWELL, dw);
		wr(`CHS_ADR_STOP_TQ, stq);
		wr(`CHS_ADR_POS_TQ, ptq);
		wr(`CHS_ADR_NEG_TQ, ntq);
		wr(`CHS_ADR_HOME_LO, {16'h0, lo});
		wr(`CHS_ADR_HOME_HI, {16'h0, hi});
		stop_at <= stop ? 8'h14 : 8'hFF;
		loads = 0;
		go(io);
		chk(ceil, dtq);
		// Home is the first index at or past switch edge plus travel
		e = stop ? 20 : ((30 + t + 15) / 16) * 16;
		rc = 0;
		lc = 0;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge CLK_SYS);
			n++;
			if (run === 1'b1) rc++;
			else if (rc > 0) lc++;
			if (!stop && run === 1'b1 && pos == (rv ? -e : e)) chk(creep, 1);
			if (rc == 3 && run === 1'b1) begin
				chk(ceil, stop ? stq : dtq);
				chk(rev, rv);
				chk(creep, 0);
			end
		end
		if (n >= 4000) errors++;
		chk(pos, rv ? -e : e);
		if (stop) chk(lc >= dw * MSC && lc <= (dw + 2) * MSC + 8, 1);
		chk(torque_limit_reached, stop);
		chk(ceil, dtq);
		if (io) lasthp = {hi, lo};
		chk(hpos, lasthp);
		chk(loads, io);
		rd(`CHS_ADR_STATUS, 32'h1400 | stop);
		rd(`CHS_ADR_IRQ_STAT, 1 | (stop << 2));
		wr(`CHS_ADR_IRQ_MASK, 0);
		@(posedge CLK_SYS);
		chk(irq, 0);
		wr(`CHS_ADR_IRQ_MASK, 3);
		@(posedge CLK_SYS);
		chk(irq, 1);
		wr(`CHS_ADR_IRQ_STAT, 7);
		@(posedge CLK_SYS);
		chk(irq, 0);
	endtask

	task end_sim;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: all runs need well under 10000 cycles
	initial begin
		#200000;
		errors++;
		end_sim();
	end

	initial begin
		void'($urandom(32'hCB56));
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		chk(ceil, `CHS_RST_TQ);
		rd(`CHS_ADR_METHOD, `CHS_RST_METHOD);
		rd(`CHS_ADR_DWELL, `CHS_RST_DWELL);
		rd(`CHS_ADR_POS_TQ, `CHS_RST_TQ);
		rd(6'h30, 32'h0);
		wr(`CHS_ADR_IRQ_MASK, 3);
		for (int i = 0; i < 8; i++) home(mt[i % 4], (i % 4) >= 2, i % 2);
		// Unknown method, then stroke end in mid-search: both abort
		for (int k = 0; k < 2; k++) begin
			wr(`CHS_ADR_METHOD, k ? 32'hFE : 32'h01);
			go(1'b0);
			repeat (10) @(posedge CLK_SYS);
			stroke <= k;
			repeat (10) @(posedge CLK_SYS);
			chk(run, 0);
			rd(`CHS_ADR_IRQ_STAT, 2);
			rd(`CHS_ADR_STATUS, 32'h402);
			stroke <= 1'b0;
			wr(`CHS_ADR_IRQ_STAT, 7);
		end
		end_sim();
	end
endmodule : chs_homing_tb
